/* sdram_addr_pkg.sv */
package sdram_addr_pkg;

    localparam int BUS_AW = 32;
    localparam int PIN_AW = 17;

    localparam logic [1:0] PORT_WIDTH_SEL_16 = 2'h1;
    localparam logic [1:0] PORT_WIDTH_SEL_32 = 2'h2;

    localparam logic [1:0] ADDR_WIDTH_SEL_01 = 2'h1;
    localparam logic [1:0] ADDR_WIDTH_SEL_10 = 2'h2;
    localparam logic [1:0] ADDR_WIDTH_SEL_11 = 2'h3;

    localparam logic [2:0] ADDRESS_GENERATION_SEL_TYPE0 = 3'h3;
    localparam logic [2:0] ADDRESS_GENERATION_SEL_TYPE1 = 3'h4;

    localparam logic [3:0] BURST_LEN_1 = 4'h1;
    localparam logic [3:0] BURST_LEN_8 = 4'h8;
    localparam logic [2:0] BEAT_LAST = 3'h7;

    // column-phase command bit: auto-precharge never requested
    localparam logic CMD_NO_AUTOPRE = 1'b0;

    localparam logic [PIN_AW-1:0] PINS_RESET = 17'h00000;
    localparam logic [3:0] LANES_RESET = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROW  = 2'b01,
        ST_COL  = 2'b10
    } phase_t;

    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [1:0] port_width_sel;
        logic [1:0] addr_width_sel;
        logic [2:0] address_generation_sel;
        logic [3:0] byte_en;
        logic burst8;
        logic write;
    } req_t;

    typedef struct packed {
        logic [PIN_AW-1:0] pins;
        logic [1:0] bank;
        logic [3:0] byte_lane_control;
        logic sdram_type1;
    } pins_out_t;

endpackage : sdram_addr_pkg

/* sdram_addr_map.sv */
`timescale 1ns/1ps
// combinational row/column multiplexer for one request
module sdram_addr_map (
    input wire sdram_addr_pkg::req_t req, // latched request, or the incoming request while idle
    input wire logic col_phase, // 1 column, 0 row
    output logic [sdram_addr_pkg::PIN_AW-1:0] pins, // external address value
    output logic [1:0] bank // bank select copy
);
    logic [4:0] sh;
    logic [31:0] a;

    always_comb begin
        a = req.addr;
        // narrower width codes move the address up, so one pin slice serves all codes
        unique case (req.addr_width_sel)
            sdram_addr_pkg::ADDR_WIDTH_SEL_11: sh = 5'h0;
            sdram_addr_pkg::ADDR_WIDTH_SEL_10: sh = 5'h1;
            default: sh = 5'h2;
        endcase
        pins = '0;
        if (req.port_width_sel == sdram_addr_pkg::PORT_WIDTH_SEL_32) begin
            if (col_phase) begin
                pins[11:2] = a[11:2];
                pins[12] = sdram_addr_pkg::CMD_NO_AUTOPRE;
                pins[16:13] = 4'((a << sh) >> 23);
            end else begin
                pins[16:2] = 15'((a << sh) >> 12);
            end
            bank = pins[16:15];
        end else begin
            if (col_phase) begin
                pins[10:1] = a[10:1];
                pins[11] = sdram_addr_pkg::CMD_NO_AUTOPRE;
                pins[15:12] = 4'((a << sh) >> 22);
            end else begin
                pins[15:1] = 15'((a << sh) >> 11);
            end
            bank = pins[15:14];
        end
    end
endmodule : sdram_addr_map

/* sdram_address_mux.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - only bursts of one or eight generated
// - short transfers masked via byte lanes
// - bursts never wrap across 8-beat boundary
// - burst address aligned to port width
// - 16-bit eight-beat burst needs A[3:1]=0
// - 32-bit eight-beat burst needs A[4:2]=0
// - port width code 10=32, 01=16
// - byte selection by lane outputs only
// - generation code 011 type0, 100 type1
// - 32-bit column: pins 11:2, cmd pin 12
// - 32-bit column upper pins per width code
// - 32-bit row pins 16:2 per width code
// - 16-bit column: pins 10:1, cmd pin 11
// - 16-bit column upper pins per width code
// - 16-bit row pins 15:1 per width code
// - auto-precharge never requested
// - top row bits double as bank select
module sdram_address_mux (
    input wire logic CORE_CLK, // system clock
    input wire logic RST_N, // synchronous reset, active low
    input wire logic REQ_VALID, // new request strobe
    input wire sdram_addr_pkg::req_t REQ, // request fields
    output logic REQ_READY, // idle, may take a request
    output logic REQ_REJECT, // one-cycle pulse: illegal request
    output logic [sdram_addr_pkg::PIN_AW-1:0] ADDR_PINS, // external address pins
    output logic [1:0] BANK_SEL, // bank select (copy of top pins)
    output logic [3:0] BYTE_LANE_CONTROL, // byte lane enables, active high
    output logic ROW_PHASE, // row address on pins
    output logic COL_PHASE, // column address on pins
    output logic [2:0] BEAT, // current beat index
    output logic BURST_LAST, // last beat of transfer
    output logic SDRAM_TYPE1 // 1 selects the type-1 set
);
    typedef struct packed {
        sdram_addr_pkg::phase_t phase;
        sdram_addr_pkg::req_t req;
        logic [2:0] beat;
        logic [3:0] beats_left;
        logic ready;
        logic reject;
        logic [sdram_addr_pkg::PIN_AW-1:0] pins;
        logic [1:0] bank;
        logic [3:0] lanes;
        logic last;
        logic type1;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    sdram_addr_pkg::req_t cur;
    logic col_sel;
    logic [sdram_addr_pkg::PIN_AW-1:0] map_pins;
    logic [1:0] map_bank;
    logic legal;
    logic is32;

    sdram_addr_map u_map (
        .req(cur),
        .col_phase(col_sel),
        .pins(map_pins),
        .bank(map_bank)
    );

    // legality of an incoming request
    always_comb begin
        is32 = (REQ.port_width_sel == sdram_addr_pkg::PORT_WIDTH_SEL_32);
        legal = 1'b1;
        if (REQ.port_width_sel != sdram_addr_pkg::PORT_WIDTH_SEL_32 &&
            REQ.port_width_sel != sdram_addr_pkg::PORT_WIDTH_SEL_16) begin
            legal = 1'b0;
        end
        if (REQ.address_generation_sel != sdram_addr_pkg::ADDRESS_GENERATION_SEL_TYPE0 &&
            REQ.address_generation_sel != sdram_addr_pkg::ADDRESS_GENERATION_SEL_TYPE1) begin
            legal = 1'b0;
        end
        if (REQ.addr_width_sel == 2'h0) begin
            legal = 1'b0;
        end
        if (REQ.burst8) begin
            // eight-beat bursts must be width aligned and start on beat 0
            if (is32 && REQ.addr[4:0] != 5'h00) begin
                legal = 1'b0;
            end
            if (!is32 && REQ.addr[3:0] != 4'h0) begin
                legal = 1'b0;
            end
        end else begin
            if (is32 && REQ.addr[1:0] != 2'h0) begin
                legal = 1'b0;
            end
            if (!is32 && REQ.addr[0] != 1'b0) begin
                legal = 1'b0;
            end
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.reject = 1'b0;
        cur = st_r.req;
        col_sel = 1'b0;
        unique case (st_r.phase)
            sdram_addr_pkg::ST_IDLE: begin
                st_nxt.last = 1'b0;
                st_nxt.lanes = sdram_addr_pkg::LANES_RESET;
                if (REQ_VALID) begin
                    if (legal) begin
                        cur = REQ;
                        col_sel = 1'b0;
                        st_nxt.req = REQ;
                        st_nxt.phase = sdram_addr_pkg::ST_ROW;
                        st_nxt.ready = 1'b0;
                        st_nxt.beat = 3'h0;
                        st_nxt.beats_left = REQ.burst8 ? sdram_addr_pkg::BURST_LEN_8
                                                       : sdram_addr_pkg::BURST_LEN_1;
                        st_nxt.type1 = (REQ.address_generation_sel ==
                                        sdram_addr_pkg::ADDRESS_GENERATION_SEL_TYPE1);
                        st_nxt.pins = map_pins;
                        st_nxt.bank = map_bank;
                    end else begin
                        st_nxt.reject = 1'b1;
                    end
                end
            end
            sdram_addr_pkg::ST_ROW: begin
                // column address follows the row address
                col_sel = 1'b1;
                st_nxt.pins = map_pins;
                st_nxt.bank = map_bank;
                st_nxt.phase = sdram_addr_pkg::ST_COL;
                st_nxt.lanes = st_r.req.byte_en;
                st_nxt.last = (st_r.beats_left == sdram_addr_pkg::BURST_LEN_1);
            end
            sdram_addr_pkg::ST_COL: begin
                // beats advance linearly; pins stay at burst start
                col_sel = 1'b1;
                if (st_r.last) begin
                    st_nxt.phase = sdram_addr_pkg::ST_IDLE;
                    st_nxt.ready = 1'b1;
                    st_nxt.last = 1'b0;
                    st_nxt.lanes = sdram_addr_pkg::LANES_RESET;
                    st_nxt.beats_left = 4'h0;
                end else begin
                    st_nxt.beat = st_r.beat + 3'h1;
                    st_nxt.beats_left = st_r.beats_left - 4'h1;
                    st_nxt.last = (st_r.beat + 3'h1 == sdram_addr_pkg::BEAT_LAST);
                end
            end
            default: begin
                st_nxt.phase = sdram_addr_pkg::ST_IDLE;
                st_nxt.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_r.phase <= sdram_addr_pkg::ST_IDLE;
            st_r.req <= '0;
            st_r.beat <= 3'h0;
            st_r.beats_left <= 4'h0;
            st_r.ready <= 1'b1;
            st_r.reject <= 1'b0;
            st_r.pins <= sdram_addr_pkg::PINS_RESET;
            st_r.bank <= 2'h0;
            st_r.lanes <= sdram_addr_pkg::LANES_RESET;
            st_r.last <= 1'b0;
            st_r.type1 <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign REQ_READY = st_r.ready;
    assign REQ_REJECT = st_r.reject;
    assign ADDR_PINS = st_r.pins;
    assign BANK_SEL = st_r.bank;
    assign BYTE_LANE_CONTROL = st_r.lanes;
    assign ROW_PHASE = (st_r.phase == sdram_addr_pkg::ST_ROW);
    assign COL_PHASE = (st_r.phase == sdram_addr_pkg::ST_COL);
    assign BEAT = st_r.beat;
    assign BURST_LAST = st_r.last;
    assign SDRAM_TYPE1 = st_r.type1;
endmodule : sdram_address_mux

/* sdram_dev_model.sv */
`timescale 1ns/1ps
// far-side device: opens row and bank on activate; has no column-cycle input
module sdram_dev_model (
    input wire logic clk, // system clock
    input wire logic row_phase, // activate cycle
    input wire logic [sdram_addr_pkg::PIN_AW-1:0] pins, // address pins
    input wire logic [1:0] bank, // bank select pins
    output logic [sdram_addr_pkg::PIN_AW-1:0] row_r, // open row
    output logic [1:0] bank_r // open bank
);
    always_ff @(posedge clk) begin
        if (row_phase) begin
            row_r <= pins;
            bank_r <= bank;
        end
    end
endmodule : sdram_dev_model

/* sdram_address_mux_assertions.sv */
`timescale 1ns/1ps
module sdram_address_mux_assertions (
    input wire logic CORE_CLK, // clock
    input wire logic RST_N, // reset
    input wire logic REQ_VALID, // strobe
    input wire sdram_addr_pkg::req_t REQ, // request
    input wire logic REQ_READY, // idle
    input wire logic REQ_REJECT, // drop pulse
    input wire logic [sdram_addr_pkg::PIN_AW-1:0] ADDR_PINS, // pins
    input wire logic [1:0] BANK_SEL, // bank
    input wire logic [3:0] BYTE_LANE_CONTROL, // lanes
    input wire logic ROW_PHASE, // row
    input wire logic COL_PHASE, // column
    input wire logic [2:0] BEAT, // beat
    input wire logic BURST_LAST, // last
    input wire logic SDRAM_TYPE1 // type
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sdram_addr_pkg::req_t req_q;
    logic pw32;
    logic bad8;
    always_ff @(posedge CORE_CLK) if (REQ_VALID && REQ_READY) req_q <= REQ;
    assign pw32 = req_q.port_width_sel == sdram_addr_pkg::PORT_WIDTH_SEL_32;
    assign bad8 = REQ.burst8 && (REQ.addr[3:0] != 4'h0 ||
        (REQ.port_width_sel == sdram_addr_pkg::PORT_WIDTH_SEL_32 && REQ.addr[4]));
    property p_b1; ROW_PHASE && !req_q.burst8 |=> COL_PHASE && BURST_LAST ##1 !COL_PHASE;
    endproperty
    a_b1: assert property (p_b1) else $error("single access length");
    property p_b8; ROW_PHASE && req_q.burst8 |=> (COL_PHASE && !BURST_LAST)[*7] ##1 BURST_LAST;
    endproperty
    a_b8: assert property (p_b8) else $error("burst length");
    property p_beat; COL_PHASE && !BURST_LAST |=> BEAT == $past(BEAT) + 3'h1; endproperty
    a_beat: assert property (p_beat) else $error("beat order");
    property p_lane; BYTE_LANE_CONTROL == (COL_PHASE ? req_q.byte_en : 4'h0); endproperty
    a_lane: assert property (p_lane) else $error("byte lanes");
    property p_cmd; COL_PHASE |-> !ADDR_PINS[pw32 ? 12 : 11]; endproperty
    a_cmd: assert property (p_cmd) else $error("precharge bit");
    property p_col; COL_PHASE |-> (pw32 ? ADDR_PINS[11:2] == req_q.addr[11:2] :
        ADDR_PINS[10:1] == req_q.addr[10:1]); endproperty
    a_col: assert property (p_col) else $error("column bits");
    property p_bank; ROW_PHASE || COL_PHASE |-> BANK_SEL == (pw32 ? ADDR_PINS[16:15] :
        ADDR_PINS[15:14]); endproperty
    a_bank: assert property (p_bank) else $error("bank select");
    property p_type; ROW_PHASE |-> SDRAM_TYPE1 == req_q.address_generation_sel[2]; endproperty
    a_type: assert property (p_type) else $error("type select");
    property p_rej; REQ_VALID && REQ_READY && bad8 |=> REQ_REJECT && !ROW_PHASE; endproperty
    a_rej: assert property (p_rej) else $error("unaligned burst");
    // the bench paces its requests on ready, so a late ready would only show as a timeout
    property p_rdy; COL_PHASE && BURST_LAST |=> REQ_READY && !ROW_PHASE && !COL_PHASE &&
        BYTE_LANE_CONTROL == 4'h0; endproperty
    a_rdy: assert property (p_rdy) else $error("transfer end");
    c_b8: cover property (ROW_PHASE && req_q.burst8);
    c_b1: cover property (ROW_PHASE && !req_q.burst8);
    c_rej: cover property (REQ_REJECT);
endmodule : sdram_address_mux_assertions
bind sdram_address_mux sdram_address_mux_assertions u_chk (.CORE_CLK, .RST_N, .REQ_VALID, .REQ,
    .REQ_READY, .REQ_REJECT, .ADDR_PINS, .BANK_SEL, .BYTE_LANE_CONTROL, .ROW_PHASE, .COL_PHASE,
    .BEAT, .BURST_LAST, .SDRAM_TYPE1);

/* sdram_address_mux_tb_top.sv */
`timescale 1ns/1ps
module sdram_address_mux_tb_top;
    typedef struct packed {
        logic rej;
        logic t1;
        logic [1:0] bank;
        logic [3:0] lanes;
        logic [16:0] row;
        logic [16:0] col;
    } exp_t;
    logic CORE_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic REQ_VALID = 1'b0;
    sdram_addr_pkg::req_t REQ = '0;
    sdram_addr_pkg::req_t r;
    logic REQ_READY, REQ_REJECT, ROW_PHASE, COL_PHASE, BURST_LAST, SDRAM_TYPE1;
    logic [16:0] ADDR_PINS, row_m;
    logic [1:0] BANK_SEL, bank_m;
    logic [3:0] BYTE_LANE_CONTROL;
    logic [2:0] BEAT;
    exp_t q[$];
    exp_t e;
    int num_errors = 0;
    int num_checks = 0;
    int seed = 32'h3cdb;
    always #2.5 CORE_CLK = ~CORE_CLK;
    sdram_address_mux u_dut (.CORE_CLK, .RST_N, .REQ_VALID, .REQ, .REQ_READY, .REQ_REJECT,
        .ADDR_PINS, .BANK_SEL, .BYTE_LANE_CONTROL, .ROW_PHASE, .COL_PHASE, .BEAT, .BURST_LAST,
        .SDRAM_TYPE1);
    sdram_dev_model u_mem (.clk(CORE_CLK), .row_phase(ROW_PHASE), .pins(ADDR_PINS),
        .bank(BANK_SEL), .row_r(row_m), .bank_r(bank_m));
    function automatic exp_t expect_of(sdram_addr_pkg::req_t x);
        logic [31:0] a;
        logic w;
        exp_t v;
        w = x.port_width_sel == sdram_addr_pkg::PORT_WIDTH_SEL_32;
        a = x.addr << (2'h3 - x.addr_width_sel); // width code 11/10/01 slides by 0/1/2
        v.rej = !((w || x.port_width_sel == sdram_addr_pkg::PORT_WIDTH_SEL_16) && x.addr_width_sel != 2'h0
            && x.address_generation_sel inside {sdram_addr_pkg::ADDRESS_GENERATION_SEL_TYPE0,
            sdram_addr_pkg::ADDRESS_GENERATION_SEL_TYPE1} && !x.addr[0] && !(w && x.addr[1])
            && !(x.burst8 && (x.addr[3:1] != 3'h0 || (w && x.addr[4]))));
        v.t1 = x.address_generation_sel == sdram_addr_pkg::ADDRESS_GENERATION_SEL_TYPE1;
        v.lanes = x.byte_en;
        v.row = w ? {a[26:12], 2'h0} : {1'b0, a[25:11], 1'b0};
        v.col = w ? {a[26:23], 1'b0, x.addr[11:2], 2'h0}
            : {1'b0, a[25:22], 1'b0, x.addr[10:1], 1'b0};
        v.bank = w ? v.row[16:15] : v.row[15:14];
        return v;
    endfunction : expect_of
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic summarize();
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic send(sdram_addr_pkg::req_t x);
        int n;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (REQ_READY !== 1'b1 && n < 40);
        if (n >= 40) begin
            num_errors++;
            summarize();
        end
        REQ_VALID <= 1'b1;
        REQ <= x;
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b0;
        q.push_back(expect_of(x));
    endtask : send
    always @(posedge CORE_CLK) begin
        if (RST_N && (REQ_REJECT === 1'b1 || (COL_PHASE === 1'b1 && BEAT === 3'h0))) begin
            e = q.pop_front();
            chk("reject", REQ_REJECT, e.rej);
            if (!e.rej) begin
                chk("row", row_m, e.row);
                chk("col", ADDR_PINS, e.col);
                chk("bank", bank_m, e.bank);
                chk("lanes", BYTE_LANE_CONTROL, e.lanes);
                chk("type", SDRAM_TYPE1, e.t1);
            end
        end
    end
    initial begin
        repeat (20) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 48; i++) begin
            r = 45'({$random(seed), $random(seed)});
            r.port_width_sel = i[0] ? sdram_addr_pkg::PORT_WIDTH_SEL_32 : sdram_addr_pkg::PORT_WIDTH_SEL_16;
            r.addr_width_sel = 2'(i % 3 + 1);
            r.address_generation_sel = i[1] ? 3'h4 : 3'h3; // setting alternates every two requests
            r.burst8 = i[2];
            if (i % 5 != 0) r.addr[4:0] = (i % 5 == 1) ? {r.addr[4:2], 2'h0} : 5'h0;
            if (i % 9 == 8) r.address_generation_sel = 3'(i % 8);
            if (i == 20) r.addr_width_sel = 2'h0;
            if (i == 30) r.port_width_sel = 2'h0;
            send(r);
        end
        repeat (20) @(posedge CORE_CLK);
        chk("pending", q.size(), 0);
        summarize();
    end
endmodule : sdram_address_mux_tb_top
